// ---- rtl/cmd_ring_pkg.sv ----
// =====================================================================
// constants and types shared by the command ring fetch logic
package cmd_ring_pkg;
  // =====================================================================
  // ring indices and geometry
  localparam int NUM_RINGS = 2;
  localparam int RING_LP = 0;
  localparam int RING_IRQ = 1;
  localparam int START_W = 20;  // page number of a 4 KB aligned base
  localparam int LEN_W = 9;  // pages minus one, 512 pages = 2 MB
  localparam int HEAD_W = 19;  // dword offset inside a 2 MB ring
  localparam int TAIL_W = 18;  // qword offset inside a 2 MB ring
  localparam int WRAP_W = 11;  // 2048 virtual ring lengths
  localparam int DMA_W = 17;  // double-qword offset
  localparam logic [9:0] PAGE_LAST_DW = 10'h3ff;
  localparam logic [11:0] PAGE_ZERO = 12'h000;
  // =====================================================================
  // head reporting
  localparam int CLK_PERIOD_NS = 50;
  localparam int REPORT_PERIOD_NS = 10000;
  localparam int REPORT_CYCLES = REPORT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] LP_REPORT_DISP = 12'h030;
  localparam logic [11:0] IRQ_REPORT_DISP = 12'h034;
  localparam logic [5:0] REPORT_HEAD_OP = 6'h07;
  // =====================================================================
  // client field decode and sequencer states
  localparam logic [2:0] CLIENT_PARSER = 3'h0;
  localparam logic [2:0] CLIENT_2D = 3'h2;
  localparam logic [2:0] CLIENT_3D = 3'h3;
  typedef enum logic [3:0] {
    DEST_PARSER = 4'b0001,
    DEST_2D = 4'b0010,
    DEST_3D = 4'b0100,
    DEST_OTHER = 4'b1000
  } dest_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_REPORT = 4'b1000
  } state_type;
  // =====================================================================
  // ring configuration fields, held by software
  typedef struct packed {
    logic valid;
    logic [START_W-1:0] start;
    logic [LEN_W-1:0] len;
  } ring_cfg_type;
endpackage

// ---- rtl/cmd_ring_fetch.sv ----
`timescale 1ns/1ps
module cmd_ring_fetch (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // ring registers, decoded from the 512 KB map outside this block
  input wire cmd_ring_pkg::ring_cfg_type [1:0] cfg_i,
  input wire logic [1:0] auto_report_i,
  input wire logic [1:0] head_wr_i,
  input wire logic [18:0] head_wdata_i,
  input wire logic [1:0] tail_wr_i,
  input wire logic [17:0] tail_wdata_i,
  input wire logic [19:0] hw_status_page_reg_i,
  output logic [1:0][31:0] head_ptr_o,
  output logic [1:0][16:0] dma_ptr_o,
  output logic [1:0] ring_empty_o,
  // instruction read port
  output logic rd_req_o,
  output logic [31:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i,
  // status page write port
  output logic wr_req_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  input wire logic wr_ack_i,
  // instruction output to engines
  output logic out_valid_o,
  output logic [31:0] out_data_o,
  output cmd_ring_pkg::dest_type out_dest_o,
  input wire logic out_ready_i
);
  // =====================================================================
  // helpers
  // step a dword offset, returning to zero past the last programmed page
  function automatic logic [18:0] next_dw(input logic [18:0] off, input logic [8:0] len);
    next_dw = (off == {len, cmd_ring_pkg::PAGE_LAST_DW}) ? 19'h00000 : off + 19'h00001;
  endfunction

  function automatic logic [31:0] byte_addr(input logic [19:0] page, input logic [18:0] off);
    byte_addr = {page, cmd_ring_pkg::PAGE_ZERO} + {11'h000, off, 2'h0};
  endfunction

  function automatic cmd_ring_pkg::dest_type client(input logic [31:0] d);
    case (d[31:29])
      cmd_ring_pkg::CLIENT_PARSER: client = cmd_ring_pkg::DEST_PARSER;
      cmd_ring_pkg::CLIENT_2D: client = cmd_ring_pkg::DEST_2D;
      cmd_ring_pkg::CLIENT_3D: client = cmd_ring_pkg::DEST_3D;
      default: client = cmd_ring_pkg::DEST_OTHER;
    endcase
  endfunction

  // =====================================================================
  // state
  cmd_ring_pkg::state_type state;
  logic [18:0] head [2];
  logic [10:0] wrap [2];
  logic [18:0] fptr [2];
  logic [17:0] tail [2];
  logic [1:0] rep_pend;
  logic act;
  logic rep_ring;
  logic [7:0] rep_cnt;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // =====================================================================
  // decode
  // both rings are one structure; only the fetch and report pick order and the report displacement differ
  wire report_tick;
  wire rep_instr;
  wire [1:0] pend;
  wire [1:0] empty;
  wire [1:0] rep_set;
  wire [1:0] rep_clr;
  for (genvar g = 0; g < 2; g++) begin : g_ring
    // fetch compares against the fetch pointer, so prefetch stops at tail
    assign pend[g] = cfg_i[g].valid && (fptr[g] != {tail[g], 1'b0});
    assign empty[g] = head[g] == {tail[g], 1'b0};
    assign rep_set[g] = (report_tick && auto_report_i[g])
                      || (rep_instr && act == 1'(g));
    assign rep_clr[g] = (state == cmd_ring_pkg::ST_REPORT) && wr_ack_i && rep_ring == 1'(g);
    // head register format: wrap count, dword offset, two zero bits
    assign head_ptr_o[g] = {wrap[g], head[g], 2'h0};
    assign dma_ptr_o[g] = fptr[g][18:2];
  end

  assign report_tick = rep_cnt == 8'(cmd_ring_pkg::REPORT_CYCLES - 1);
  wire pick = pend[cmd_ring_pkg::RING_IRQ];
  wire fetched = (state == cmd_ring_pkg::ST_FETCH) && rd_ack_i;
  wire accept = out_valid_o && out_ready_i;
  wire [8:0] act_len = cfg_i[act].len;
  wire head_last = head[act] == {act_len, cmd_ring_pkg::PAGE_LAST_DW};
  assign rep_instr = accept && out_dest_o == cmd_ring_pkg::DEST_PARSER
                   && out_data_o[28:23] == cmd_ring_pkg::REPORT_HEAD_OP;
  wire [11:0] rep_disp = rep_pend[cmd_ring_pkg::RING_IRQ] ? cmd_ring_pkg::IRQ_REPORT_DISP
                                                           : cmd_ring_pkg::LP_REPORT_DISP;
  wire next_rep_ring = rep_pend[cmd_ring_pkg::RING_IRQ];

  // =====================================================================
  // report period divider, free running so reports stay periodic
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rep_cnt <= 8'h00;
    end else if (report_tick) begin
      rep_cnt <= 8'h00;
    end else begin
      rep_cnt <= rep_cnt + 8'h01;
    end
  end

  // =====================================================================
  // per-ring pointers
  // head write reloads the fetch pointer too; valid never touches either
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int r = 0; r < 2; r++) begin
        head[r] <= 19'h00000;
        wrap[r] <= 11'h000;
        fptr[r] <= 19'h00000;
        tail[r] <= 18'h00000;
      end
      rep_pend <= 2'h0;
      ring_empty_o <= 2'h3;
    end else begin
      for (int r = 0; r < 2; r++) begin
        if (head_wr_i[r]) begin
          head[r] <= head_wdata_i;
          fptr[r] <= head_wdata_i;
        end else begin
          if (accept && act == 1'(r)) begin
            head[r] <= next_dw(head[r], act_len);
            if (head_last) begin
              wrap[r] <= wrap[r] + 11'h001;
            end
          end
          if (fetched && act == 1'(r)) begin
            fptr[r] <= next_dw(fptr[r], act_len);
          end
        end
        // a smaller tail is just a wrapped submission, no special case
        if (tail_wr_i[r]) begin
          tail[r] <= tail_wdata_i;
        end
        ring_empty_o[r] <= empty[r];
      end
      // a new report request wins over the clear of the previous one
      rep_pend <= rep_set | (rep_pend & ~rep_clr);
    end
  end

  // =====================================================================
  // fetch and report sequencer
  // one read in flight keeps prefetch to a single dword past head
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= cmd_ring_pkg::ST_IDLE;
      act <= 1'b0;
      rep_ring <= 1'b0;
      rd_req_o <= 1'b0;
      rd_addr_o <= 32'h00000000;
      wr_req_o <= 1'b0;
      wr_addr_o <= 32'h00000000;
      wr_data_o <= 32'h00000000;
      out_valid_o <= 1'b0;
      out_data_o <= 32'h00000000;
      out_dest_o <= cmd_ring_pkg::DEST_PARSER;
    end else begin
      unique case (state)
        cmd_ring_pkg::ST_IDLE: begin
          if (|rep_pend) begin
            state <= cmd_ring_pkg::ST_REPORT;
            rep_ring <= next_rep_ring;
            wr_req_o <= 1'b1;
            wr_addr_o <= {hw_status_page_reg_i, rep_disp};
            wr_data_o <= head_ptr_o[next_rep_ring];
          end else if (|pend) begin
            // interrupt ring first; low-priority only when it is idle
            state <= cmd_ring_pkg::ST_FETCH;
            act <= pick;
            rd_req_o <= 1'b1;
            rd_addr_o <= byte_addr(cfg_i[pick].start, fptr[pick]);
          end
        end
        cmd_ring_pkg::ST_FETCH: begin
          if (rd_ack_i) begin
            state <= cmd_ring_pkg::ST_HOLD;
            rd_req_o <= 1'b0;
            out_valid_o <= 1'b1;
            out_data_o <= rd_data_i;
            out_dest_o <= client(rd_data_i);
          end
        end
        cmd_ring_pkg::ST_HOLD: begin
          if (out_ready_i) begin
            state <= cmd_ring_pkg::ST_IDLE;
            out_valid_o <= 1'b0;
          end
        end
        cmd_ring_pkg::ST_REPORT: begin
          if (wr_ack_i) begin
            state <= cmd_ring_pkg::ST_IDLE;
            wr_req_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // checks
  a_no_fetch_empty: assert property (
    $rose(rd_req_o) |-> fptr[act] != {tail[act], 1'b0} && cfg_i[act].valid)
    else $error("fetch started on an empty ring");

  a_head_retire: assert property (
    accept && !head_wr_i[act] |=> head[$past(act)] == $past(next_dw(head[act], act_len)))
    else $error("head did not advance on retirement");

  a_wrap_count: assert property (
    accept && head_last && !head_wr_i[act]
    |=> wrap[$past(act)] == $past(wrap[act]) + 11'h001 && head[$past(act)] == 19'h00000)
    else $error("wrap count did not follow head wrap");

  a_enable_keeps_head: assert property (
    $rose(cfg_i[0].valid) && !head_wr_i[0] && !(accept && !act) |=> $stable(head[0]))
    else $error("enabling the ring changed its head");

  a_prefetch_ahead: assert property (
    state == cmd_ring_pkg::ST_HOLD && !$past(head_wr_i[act])
    |-> fptr[act] == next_dw(head[act], act_len))
    else $error("fetch pointer not one dword past head");

  sequence s_fetch_done;
    fetched && (fptr[act] == {act_len, cmd_ring_pkg::PAGE_LAST_DW}) && !head_wr_i[act];
  endsequence
  a_dma_wrap: assert property (
    s_fetch_done |=> fptr[$past(act)] == 19'h00000)
    else $error("fetch pointer did not wrap to zero");

  a_report_data: assert property (
    $rose(wr_req_o) |-> wr_data_o == (rep_ring ? $past(head_ptr_o[1]) : $past(head_ptr_o[0]))
      && wr_addr_o[11:0] == (rep_ring ? cmd_ring_pkg::IRQ_REPORT_DISP
                                      : cmd_ring_pkg::LP_REPORT_DISP))
    else $error("report carries the wrong head value");

  a_report_instr: assert property (
    rep_instr && state == cmd_ring_pkg::ST_HOLD |=> rep_pend[$past(act)] ##1
      state == cmd_ring_pkg::ST_REPORT)
    else $error("report instruction did not start a report");

  a_client_route: assert property (
    out_valid_o |-> out_dest_o == client(out_data_o) && $stable(out_data_o) || $rose(out_valid_o))
    else $error("instruction routed to the wrong engine");

  // =====================================================================
  // handshake, arbitration and pointer checks
  a_read_holds: assert property (
    rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o))
    else $error("read request dropped before its answer");

  a_write_holds: assert property (
    wr_req_o && !wr_ack_i |=> wr_req_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("report write dropped before its answer");

  a_irq_first: assert property (
    state == cmd_ring_pkg::ST_IDLE && rep_pend == 2'h0 && pend[cmd_ring_pkg::RING_IRQ]
    |=> rd_req_o && act)
    else $error("interrupt ring was not served first");

  a_empty_idle: assert property (
    state == cmd_ring_pkg::ST_IDLE && rep_pend == 2'h0 && pend == 2'h0
    |=> !rd_req_o && !wr_req_o)
    else $error("request issued with no work pending");

  a_valid_keeps_tail: assert property (
    $changed(cfg_i[0].valid) && !tail_wr_i[0] |=> $stable(tail[0]) && $stable(wrap[0]))
    else $error("valid toggle changed a ring pointer");
endmodule

// ---- bench/ring_mem_model.sv ----
`timescale 1ns/1ps
// =====================================================================
// system memory holding the rings and the status page
module ring_mem_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // answer delay in cycles, so the bench can be prompt or slow
  input wire logic [3:0] lag_i,
  // instruction reads
  input wire logic rd_req_i,
  input wire logic [31:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [31:0] rd_data_o,
  // status page writes
  input wire logic wr_req_i,
  output logic wr_ack_o
);
  logic [3:0] rcnt;
  logic [3:0] wcnt;
  // linear memory, contents follow the address; dword 5 of a page reports the head
  function automatic logic [31:0] word(input logic [31:0] a);
    return (a[11:2] == 10'h005) ? {3'h0, 6'h07, 23'h0} : {a[4:2], 6'h00, a[24:2]};
  endfunction
  // idle data flips every cycle so a stale word never passes for fresh
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rcnt <= 4'h0;
      wcnt <= 4'h0;
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      rd_data_o <= 32'h0;
    end else begin
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      rcnt <= (rd_req_i && !rd_ack_o) ? rcnt + 4'h1 : 4'h0;
      wcnt <= (wr_req_i && !wr_ack_o) ? wcnt + 4'h1 : 4'h0;
      if (rd_req_i && !rd_ack_o && rcnt == lag_i) begin
        rd_ack_o <= 1'b1;
        rd_data_o <= word(rd_addr_i);
      end
      if (wr_req_i && !wr_ack_o && wcnt == lag_i) begin
        wr_ack_o <= 1'b1;
      end
    end
  end
endmodule

// ---- bench/test_cmd_ring_fetch.sv ----
`timescale 1ns/1ps
// =====================================================================
// bench for the command ring fetch logic
module test_cmd_ring_fetch;
  localparam logic [18:0] LAST = 19'h003ff;  // one page rings, length field 0
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  cmd_ring_pkg::ring_cfg_type [1:0] cfg = '0;
  logic [1:0] auto_rep = 2'b00;
  logic [1:0] head_wr = 2'b00;
  logic [18:0] head_wdata = 19'h0;
  logic [1:0] tail_wr = 2'b00;
  logic [17:0] tail_wdata = 18'h0;
  logic [19:0] page = 20'h00abc;
  logic out_ready = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [1:0][31:0] head_ptr;
  logic [1:0][16:0] dma_ptr;
  logic [1:0] ring_empty;
  logic rd_req, rd_ack, wr_req, wr_ack, out_valid;
  logic [31:0] rd_addr, rd_data, wr_addr, wr_data, out_data;
  cmd_ring_pkg::dest_type out_dest;
  logic [18:0] hd [2];
  logic [10:0] wr [2];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  cmd_ring_fetch cmd_ring_fetch_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cfg_i(cfg), .auto_report_i(auto_rep),
    .head_wr_i(head_wr), .head_wdata_i(head_wdata), .tail_wr_i(tail_wr),
    .tail_wdata_i(tail_wdata), .hw_status_page_reg_i(page), .head_ptr_o(head_ptr),
    .dma_ptr_o(dma_ptr), .ring_empty_o(ring_empty), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
    .rd_ack_i(rd_ack), .rd_data_i(rd_data), .wr_req_o(wr_req), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_ack_i(wr_ack), .out_valid_o(out_valid), .out_data_o(out_data),
    .out_dest_o(out_dest), .out_ready_i(out_ready));
  ring_mem_model ring_mem_model_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .lag_i(lag), .rd_req_i(rd_req),
    .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_data_o(rd_data), .wr_req_i(wr_req),
    .wr_ack_o(wr_ack));
  // =====================================================================
  // clock and hang guard
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // =====================================================================
  // helpers
  function automatic logic [31:0] word(input logic [31:0] a);
    return (a[11:2] == 10'h005) ? {3'h0, 6'h07, 23'h0} : {a[4:2], 6'h00, a[24:2]};
  endfunction
  function automatic cmd_ring_pkg::dest_type dest_of(input logic [31:0] w);
    case (w[31:29])
      3'h0: return cmd_ring_pkg::DEST_PARSER;
      3'h2: return cmd_ring_pkg::DEST_2D;
      3'h3: return cmd_ring_pkg::DEST_3D;
      default: return cmd_ring_pkg::DEST_OTHER;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // pointers change only while the ring is invalid, then it is enabled
  task automatic prog(input int r, input logic [18:0] h, input logic [17:0] t);
    cfg[r].valid = 1'b0;
    @(negedge sys_clk_i);
    head_wr[r] = 1'b1;
    head_wdata = h;
    tail_wr[r] = 1'b1;
    tail_wdata = t;
    @(negedge sys_clk_i);
    head_wr = 2'b00;
    tail_wr = 2'b00;
    hd[r] = h;
    @(negedge sys_clk_i);
    chk(32'(head_ptr[r][20:2]), 32'(h));
    cfg[r].valid = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(32'(head_ptr[r][20:2]), 32'(h));
  endtask
  // one dword: address, data, route, stall with head held, then retire
  task automatic take(input int r, input int stall);
    logic [31:0] a;
    logic [18:0] nx;
    int k;
    a = {cfg[r].start, 12'h000} + {11'h0, hd[r], 2'b00};
    nx = (hd[r] == LAST) ? 19'h0 : hd[r] + 19'h1;
    for (k = 0; k < 50 && rd_req !== 1'b1; k++) @(negedge sys_clk_i);
    chk(32'(rd_req), 32'h1);
    chk(rd_addr, a);
    for (k = 0; k < 50 && out_valid !== 1'b1; k++) @(negedge sys_clk_i);
    chk(32'(out_valid), 32'h1);
    chk(out_data, word(a));
    chk(32'(out_dest), 32'(dest_of(word(a))));
    repeat (stall) @(negedge sys_clk_i);
    chk(32'(dma_ptr[r]), 32'(nx[18:2]));
    chk(head_ptr[r], {wr[r], hd[r], 2'b00});
    out_ready = 1'b1;
    @(negedge sys_clk_i);
    out_ready = 1'b0;
    if (nx == 19'h0) wr[r] = wr[r] + 11'h1;
    hd[r] = nx;
    chk(head_ptr[r], {wr[r], hd[r], 2'b00});
  endtask
  task automatic idle_check(input int r);
    repeat (8) @(negedge sys_clk_i);
    chk(32'(rd_req), 32'h0);
    chk(32'(ring_empty[r]), 32'h1);
  endtask
  task automatic see_rep(input logic [11:0] disp, input logic [18:0] h);
    int k;
    for (k = 0; k < 300 && wr_req !== 1'b1; k++) @(negedge sys_clk_i);
    chk(32'(wr_req), 32'h1);
    chk(wr_addr, {page, disp});
    chk(wr_data, {11'h0, h, 2'b00});
    for (k = 0; k < 20 && wr_req === 1'b1; k++) @(negedge sys_clk_i);
    chk(32'(wr_req), 32'h0);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    cfg[0].start = 20'h00100;  // page numbers keep bases 4 KB aligned
    cfg[1].start = 20'h00200;
    hd[0] = 19'h0;
    hd[1] = 19'h0;
    wr[0] = 11'h0;
    wr[1] = 11'h0;
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    chk(head_ptr[0], 32'h0);
    chk(32'(ring_empty), 32'h3);
    chk(32'(rd_req), 32'h0);
    // both rings, prompt then slow memory, pending words at enable
    for (int r = 0; r < 2; r++) begin
      lag = 4'(r * 3);
      prog(r, 19'h00008, 18'h00006);
      for (int i = 0; i < 4; i++) take(r, i);
      idle_check(r);
    end
    // report-head word sits at dword 5 of the low-priority ring
    prog(0, 19'h00004, 18'h00003);
    take(0, 0);
    take(0, 1);
    see_rep(12'h030, 19'h00006);
    auto_rep = 2'b01;
    see_rep(12'h030, 19'h00006);
    auto_rep = 2'b10;
    see_rep(12'h034, 19'h0000c);
    auto_rep = 2'b00;
    // smaller tail submits words that wrap past the ring end
    prog(0, LAST - 19'h00003, 18'h00002);
    for (int i = 0; i < 8; i++) take(0, 1);
    idle_check(0);
    wrap_up();
  end
endmodule
